// ==== core/rsp_rtc_status.v ====
// rtc status flags, shadow sync, init handshake and prescaler register
//
// Notes on behaviour
// - calib write outside init raises pending flag
// - each tamper input sets own sticky flag
// - stamp while stamp flag set sets overflow
// - each stamp event sets sticky stamp flag
// - alarm match sets flag, cleared writing zero
// - init request bit stops calendar counter
// - init state flag gates calendar, prescaler writes
// - every two rtc clocks copy shadow, set sync
// - init, shift, bypass or zero-write clear sync
// - nonzero year field sets year mark
// - shift pending flag mirrors pending shift
// - alarm writable flag once alarm enable cleared
// - system reset clears only init and sync bits
// - status protected except bits 14:8
// - prescaler writes need unlock and init state
// - async stage divides rtc by factor plus one
// - sync stage divides by factor plus one
// - backup reset loads prescaler default value
// - bypass makes calendar reads return live values
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "rsp_map.vh"
module rsp_rtc_status (
  // clock and resets
  input  wire        clk,
  input  wire        reset,
  input  wire        bkp_reset,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // rtc clock, sampled as a level
  input  wire        rtc_source_clock,
  // control levels from the rest of the rtc
  input  wire        write_unlocked,
  input  wire        shadow_bypass,
  input  wire        alarm_enable,
  input  wire        shift_pending,
  // event pulses from the rtc core
  input  wire        stamp_event,
  input  wire        tamper_a_detect,
  input  wire        tamper_b_detect,
  input  wire        alarm_match,
  input  wire        smooth_calib_reg_wr,
  input  wire        calib_applied,
  // live calendar words
  input  wire [31:0] live_time,
  input  wire [31:0] live_date,
  // outputs to the calendar core
  output wire        counters_halt,
  output wire        calendar_write_ok,
  output wire        async_divided_clock,
  output wire        second_tick_clock
);

  // next value of a sticky flag; a set always beats a clear
  function flag_next;
    input cur;
    input set;
    input clr;
    begin
      flag_next = set | (cur & ~clr);
    end
  endfunction

  // true when the offset names one of our registers
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `RSP_OFS_TIME) || (a == `RSP_OFS_DATE) ||
                  (a == `RSP_OFS_STAT) || (a == `RSP_OFS_PSC);
    end
  endfunction

  // ---------------- bus write side ----------------
  reg        aw_held_reg;     // write address taken, waiting for data
  reg [7:0]  aw_addr_reg;     // captured write address
  reg        w_held_reg;      // write data taken, waiting for address
  reg [31:0] w_data_reg;      // captured write data
  reg [3:0]  w_strb_reg;      // captured byte strobes

  // each channel is accepted once, in either order
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;

  // one cycle in which the whole write is carried out
  wire wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  // partial words are refused; software must use full words
  wire wr_full = (w_strb_reg == `RSP_STRB_FULL);
  wire wr_stat = wr_fire & wr_full & (aw_addr_reg == `RSP_OFS_STAT);
  wire wr_psc  = wr_fire & wr_full & (aw_addr_reg == `RSP_OFS_PSC);
  // protected status fields need the unlock
  wire wr_stat_prot = wr_stat & write_unlocked;

  // write channel capture and response
  always @(posedge clk) begin
    if (reset || bkp_reset) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped or partial word gets an error and no effect
        if (is_mapped(aw_addr_reg) && wr_full) begin
          s_axi_bresp <= `RSP_RESP_OKAY;
        end else begin
          s_axi_bresp <= `RSP_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- rtc clock edge ----------------
  reg  rtc_prev_reg;          // last sampled rtc level
  wire rtc_tick = rtc_source_clock & ~rtc_prev_reg;

  // edge detect on the rtc level input
  always @(posedge clk) begin
    if (reset || bkp_reset) begin
      rtc_prev_reg <= 1'b0;
    end else begin
      rtc_prev_reg <= rtc_source_clock;
    end
  end

  // ---------------- status flags ----------------
  reg calib_pending_flag_reg;   // smooth calibration pending
  reg tamper_b_flag_reg;        // second tamper input seen
  reg tamper_a_flag_reg;        // first tamper input seen
  reg stamp_overflow_flag_reg;  // stamp while stamp flag still set
  reg stamp_flag_reg;           // time stamp seen
  reg alarm_hit_flag_reg;       // alarm matched
  reg init_request_reg;         // software asks for init mode
  reg init_state_flag_reg;      // init mode reached
  reg shadow_sync_flag_reg;     // shadows hold a fresh copy
  reg alarm_writable_flag_reg;  // alarm registers may be written
  reg sync_phase_reg;           // counts rtc edges between copies
  reg [31:0] shadow_time_reg;   // shadow copy of time
  reg [31:0] shadow_date_reg;   // shadow copy of date

  // helper terms for clear-on-zero writes; a one leaves the flag
  wire clr_tamp_b = wr_stat & ~w_data_reg[`RSP_BIT_TAMP_B];
  wire clr_tamp_a = wr_stat & ~w_data_reg[`RSP_BIT_TAMP_A];
  wire clr_ovf    = wr_stat & ~w_data_reg[`RSP_BIT_OVF];
  wire clr_stamp  = wr_stat & ~w_data_reg[`RSP_BIT_STAMP];
  wire clr_alarm  = wr_stat & ~w_data_reg[`RSP_BIT_ALARM];
  wire clr_sync   = wr_stat_prot & ~w_data_reg[`RSP_BIT_SYNC];

  // conditions that keep shadows stale
  wire sync_block = init_request_reg | shift_pending |
                    shadow_bypass;
  // second rtc edge of each pair copies the calendar
  wire sync_copy  = rtc_tick & sync_phase_reg & ~sync_block;

  // year mark straight from the live date
  wire year_set_mark =
    |live_date[`RSP_YEAR_HI:`RSP_YEAR_LO];

  // event flags only see the backup reset
  always @(posedge clk) begin
    if (bkp_reset) begin
      calib_pending_flag_reg  <= 1'b0;
      tamper_b_flag_reg       <= 1'b0;
      tamper_a_flag_reg       <= 1'b0;
      stamp_overflow_flag_reg <= 1'b0;
      stamp_flag_reg          <= 1'b0;
      alarm_hit_flag_reg      <= 1'b0;
      alarm_writable_flag_reg <= 1'b1;
    end else begin
      // a calibration write made in init mode is applied at once
      calib_pending_flag_reg <= flag_next(calib_pending_flag_reg,
        smooth_calib_reg_wr & ~init_state_flag_reg,
        calib_applied);
      tamper_b_flag_reg <= flag_next(tamper_b_flag_reg,
        tamper_b_detect, clr_tamp_b);
      tamper_a_flag_reg <= flag_next(tamper_a_flag_reg,
        tamper_a_detect, clr_tamp_a);
      // the old stamp flag value decides overflow
      stamp_overflow_flag_reg <= flag_next(stamp_overflow_flag_reg,
        stamp_event & stamp_flag_reg, clr_ovf);
      stamp_flag_reg <= flag_next(stamp_flag_reg,
        stamp_event, clr_stamp);
      alarm_hit_flag_reg <= flag_next(alarm_hit_flag_reg,
        alarm_match, clr_alarm);
      // writable one clock after the alarm is disabled
      alarm_writable_flag_reg <= ~alarm_enable;
    end
  end

  // init handshake and sync flag clear on either reset
  always @(posedge clk) begin
    if (reset || bkp_reset) begin
      init_request_reg     <= 1'b0;
      init_state_flag_reg  <= 1'b0;
      shadow_sync_flag_reg <= 1'b0;
      sync_phase_reg       <= 1'b0;
    end else begin
      if (wr_stat_prot) begin
        init_request_reg <= w_data_reg[`RSP_BIT_INITREQ];
      end
      // init state is reached on the next rtc edge, left at once
      if (!init_request_reg) begin
        init_state_flag_reg <= 1'b0;
      end else if (rtc_tick) begin
        init_state_flag_reg <= 1'b1;
      end
      if (rtc_tick) begin
        sync_phase_reg <= ~sync_phase_reg;
      end
      // hardware blocking clears win; a fresh copy beats software
      if (sync_block) begin
        shadow_sync_flag_reg <= 1'b0;
      end else begin
        shadow_sync_flag_reg <= flag_next(shadow_sync_flag_reg,
          sync_copy, clr_sync);
      end
    end
  end

  // shadow copies keep their content over a system reset
  always @(posedge clk) begin
    if (bkp_reset) begin
      shadow_time_reg <= 32'h00000000;
      shadow_date_reg <= 32'h00000000;
    end else if (sync_copy) begin
      shadow_time_reg <= live_time;
      shadow_date_reg <= live_date;
    end
  end

  // ---------------- prescaler register ----------------
  reg [31:0] psc_reg;           // divider factors

  // only the backup reset touches the factors
  always @(posedge clk) begin
    if (bkp_reset) begin
      psc_reg <= `RSP_PSC_RESET;
    end else if (wr_psc && write_unlocked &&
                 init_state_flag_reg) begin
      psc_reg <= w_data_reg & `RSP_PSC_MASK;
    end
  end

  // calendar core stops counting and may be loaded in init
  assign counters_halt     = init_request_reg;
  assign calendar_write_ok = init_state_flag_reg;

  // divider chain, halted in init so it restarts from zero
  rsp_prescaler u_prescaler (
    .clk                 (clk),
    .reset               (reset | bkp_reset),
    .rtc_tick            (rtc_tick),
    .halt                (init_request_reg),
    .factor_a            (psc_reg[`RSP_FA_HI:`RSP_FA_LO]),
    .factor_s            (psc_reg[`RSP_FS_HI:`RSP_FS_LO]),
    .async_divided_clock (async_divided_clock),
    .second_tick_clock   (second_tick_clock)
  );

  // ---------------- read side ----------------
  reg [31:0] stat_word;         // assembled status image
  reg [31:0] rd_word;           // selected read value

  // status image; reserved bits 2:1 read as one, other unused bits stay zero
  always @* begin
    stat_word = 32'h00000000;
    stat_word[`RSP_BIT_CALIB]   = calib_pending_flag_reg;
    stat_word[`RSP_BIT_TAMP_B]  = tamper_b_flag_reg;
    stat_word[`RSP_BIT_TAMP_A]  = tamper_a_flag_reg;
    stat_word[`RSP_BIT_OVF]     = stamp_overflow_flag_reg;
    stat_word[`RSP_BIT_STAMP]   = stamp_flag_reg;
    stat_word[`RSP_BIT_ALARM]   = alarm_hit_flag_reg;
    stat_word[`RSP_BIT_INITREQ] = init_request_reg;
    stat_word[`RSP_BIT_INITST]  = init_state_flag_reg;
    stat_word[`RSP_BIT_SYNC]    = shadow_sync_flag_reg;
    stat_word[`RSP_BIT_YEAR]    = year_set_mark;
    stat_word[`RSP_BIT_SHIFT]   = shift_pending;
    stat_word[2:1]              = `RSP_STAT_RSVD_ONES;
    stat_word[`RSP_BIT_AWF]     = alarm_writable_flag_reg;
  end

  // read mux; bypass shows the live calendar
  always @* begin
    case (s_axi_araddr)
      `RSP_OFS_TIME: begin
        rd_word = shadow_bypass ? live_time : shadow_time_reg;
      end
      `RSP_OFS_DATE: begin
        rd_word = shadow_bypass ? live_date : shadow_date_reg;
      end
      `RSP_OFS_STAT: begin
        rd_word = stat_word;
      end
      `RSP_OFS_PSC: begin
        rd_word = psc_reg;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // one read at a time; address taken only when no data is owed
  assign s_axi_arready = ~s_axi_rvalid;

  // read data registered one cycle after the address
  always @(posedge clk) begin
    if (reset || bkp_reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RSP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      if (is_mapped(s_axi_araddr)) begin
        s_axi_rresp <= `RSP_RESP_OKAY;
      end else begin
        s_axi_rresp <= `RSP_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // rsp_rtc_status

// ==== core/rsp_map.vh ====
// register map, field positions and reset values of the rtc status block
`ifndef RSP_MAP_VH
`define RSP_MAP_VH

// byte offsets on the register bus
`define RSP_OFS_TIME        8'h00
`define RSP_OFS_DATE        8'h04
`define RSP_OFS_STAT        8'h0c
`define RSP_OFS_PSC         8'h10

// status register bit positions
`define RSP_BIT_CALIB       16
`define RSP_BIT_TAMP_B      14
`define RSP_BIT_TAMP_A      13
`define RSP_BIT_OVF         12
`define RSP_BIT_STAMP       11
`define RSP_BIT_ALARM       8
`define RSP_BIT_INITREQ     7
`define RSP_BIT_INITST      6
`define RSP_BIT_SYNC        5
`define RSP_BIT_YEAR        4
`define RSP_BIT_SHIFT       3
`define RSP_BIT_AWF         0

// reserved bits 2:1 read as one, matching the backup reset value
`define RSP_STAT_RSVD_ONES  2'b11

// reset values
`define RSP_STAT_RESET      32'h00000007
`define RSP_PSC_RESET       32'h007f00ff

// divider factor fields
`define RSP_FA_HI           22
`define RSP_FA_LO           16
`define RSP_FS_HI           14
`define RSP_FS_LO           0
`define RSP_PSC_MASK        32'h007f7fff

// year field of the live date word
`define RSP_YEAR_HI         23
`define RSP_YEAR_LO         16

// bus answer codes and full-word strobe
`define RSP_RESP_OKAY       2'b00
`define RSP_RESP_SLVERR     2'b10
`define RSP_STRB_FULL       4'hf

`endif

// ==== core/rsp_prescaler.v ====
// two-stage rtc prescaler producing the intermediate and second ticks
`timescale 1ns/1ns
module rsp_prescaler (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // rtc edge and control
  input  wire        rtc_tick,
  input  wire        halt,
  input  wire [6:0]  factor_a,
  input  wire [14:0] factor_s,
  // divided ticks, one cycle each
  output reg         async_divided_clock,
  output reg         second_tick_clock
);

  reg [6:0]  a_cnt_reg;   // asynchronous stage count
  reg [14:0] s_cnt_reg;   // synchronous stage count

  // a stage wraps after factor+1 input edges
  wire a_wrap = rtc_tick & (a_cnt_reg == factor_a);
  wire s_wrap = a_wrap & (s_cnt_reg == factor_s);

  // counters hold at zero while halted so they restart cleanly
  always @(posedge clk) begin
    if (reset || halt) begin
      a_cnt_reg           <= 7'h00;
      s_cnt_reg           <= 15'h0000;
      async_divided_clock <= 1'b0;
      second_tick_clock   <= 1'b0;
    end else begin
      async_divided_clock <= a_wrap;
      second_tick_clock   <= s_wrap;
      if (a_wrap) begin
        a_cnt_reg <= 7'h00;
      end else if (rtc_tick) begin
        a_cnt_reg <= a_cnt_reg + 7'h01;
      end
      if (s_wrap) begin
        s_cnt_reg <= 15'h0000;
      end else if (a_wrap) begin
        s_cnt_reg <= s_cnt_reg + 15'h0001;
      end
    end
  end

endmodule // rsp_prescaler

// ==== sim/rsp_status_properties.sv ====
// bus and init-handshake properties of the rtc status block
`timescale 1ns/1ns
module rsp_status_chk (
  // clock and resets
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       bkp_reset,
  // register bus
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic       s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // calendar side
  input wire logic       counters_halt,
  input wire logic       calendar_write_ok,
  input wire logic       async_divided_clock,
  input wire logic       second_tick_clock
);
  // both resets restart every relation below
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || bkp_reset);

  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not on second edge");
  AST_PART_STRB: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_wstrb != 4'hf |=> ##1 s_axi_bresp == 2'b10)
    else $error("partial strobe accepted");
  // unmapped reads give an error code and zero data
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && !(s_axi_araddr
    inside {8'h00, 8'h04, 8'h0c, 8'h10}) |=> s_axi_rresp == 2'b10 && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_INIT_RISE: assert property ($rose(calendar_write_ok) |-> counters_halt)
    else $error("init state without request");
  AST_INIT_DROP: assert property (!counters_halt |=> !calendar_write_ok)
    else $error("init state outlived request");
  AST_HALT_QUIET: assert property (counters_halt && $past(counters_halt) |->
    !async_divided_clock && !second_tick_clock)
    else $error("divider ran while halted");
  AST_SEC_ON_ASYNC: assert property (second_tick_clock |-> async_divided_clock)
    else $error("second tick without intermediate tick");
  AST_PULSE_ONE: assert property (async_divided_clock |=> !async_divided_clock)
    else $error("intermediate tick wider than one cycle");
  AST_SYSRST: assert property ($fell(reset) |-> !counters_halt && !calendar_write_ok)
    else $error("system reset left init bits set");
endmodule // rsp_status_chk

bind rsp_rtc_status rsp_status_chk u_chk (.*);

// ==== sim/tb_top.sv ====
// register-level testbench of the rtc status and prescaler block
`timescale 1ns/1ns
`include "rsp_map.vh"
module tb_top;
  // clock, resets and bus
  logic clk = 0, reset = 1, bkp_reset = 1;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_bready = 1, s_axi_rready = 1; // always ready: no stall needed
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  // rtc side stimulus
  logic rtc_source_clock = 0, write_unlocked = 0, shadow_bypass = 0;
  logic alarm_enable = 0, shift_pending = 0, stamp_event = 0;
  logic tamper_a_detect = 0, tamper_b_detect = 0, alarm_match = 0;
  logic smooth_calib_reg_wr = 0, calib_applied = 0;
  logic [31:0] live_time = 32'h00123456, live_date = 0;
  logic counters_halt, calendar_write_ok, async_divided_clock, second_tick_clock;
  // bookkeeping
  int err_total = 0, n_tests = 0, n_async = 0, n_sec = 0, a0 = 0, s0 = 0;
  logic [31:0] rd_v;
  logic [1:0]  rsp;

  always #5 clk = ~clk;

  rsp_rtc_status u_dut (.*);

  // count divider pulses as the calendar core would see them
  always @(posedge clk) begin
    if (async_divided_clock === 1'b1) n_async <= n_async + 1;
    if (second_tick_clock === 1'b1) n_sec <= n_sec + 1;
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one write; both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready) begin aw_ok = 1; s_axi_awvalid <= 0; end
      if (!w_ok && s_axi_wready) begin w_ok = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // read a word and compare the masked field
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] m, e);
    rd(a, rd_v, rsp);
    chk(nm, rd_v & m, e);
  endtask

  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, 4'hf, rsp);
    chk("wresp", {30'd0, rsp}, 0);
  endtask

  // one-cycle event pulse from the rtc core, picked by number
  task automatic pulse(input int k);
    case (k)
      0: stamp_event <= 1;
      1: tamper_a_detect <= 1;
      2: tamper_b_detect <= 1;
      3: alarm_match <= 1;
      4: smooth_calib_reg_wr <= 1;
      default: calib_applied <= 1;
    endcase
    @(posedge clk);
    {stamp_event, tamper_a_detect, tamper_b_detect, alarm_match,
     smooth_calib_reg_wr, calib_applied} <= 6'd0;
    repeat (2) @(posedge clk);
  endtask

  // rtc clock far slower than clk; idle low between bursts
  task automatic rtc(input int n);
    repeat (n) begin
      rtc_source_clock <= 1;
      repeat (3) @(posedge clk);
      rtc_source_clock <= 0;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    print_verdict;
  end

  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    bkp_reset <= 0;
    @(posedge clk);
    rchk("stat rst", `RSP_OFS_STAT, 32'hffffffff, 32'h7);
    rchk("psc rst", `RSP_OFS_PSC, 32'hffffffff, `RSP_PSC_RESET);
    // every sticky flag, stamp twice to overflow
    pulse(0);
    pulse(0);
    pulse(1);
    pulse(2);
    pulse(3);
    pulse(4);
    rchk("flags", `RSP_OFS_STAT, 32'h17900, 32'h17900);
    pulse(5);
    rchk("calib", `RSP_OFS_STAT, 32'h10000, 0);
    // locked write clears chosen flags, ones keep the rest
    wok(`RSP_OFS_STAT, 32'h00007080);
    rchk("keep", `RSP_OFS_STAT, 32'h79c0, 32'h7000);
    wok(`RSP_OFS_STAT, 0);
    rchk("clr", `RSP_OFS_STAT, 32'h7900, 0);
    wr(`RSP_OFS_STAT, 0, 4'h3, rsp);
    chk("strb", {30'd0, rsp}, `RSP_RESP_SLVERR);
    rd(8'h20, rd_v, rsp);
    chk("unmap", {rd_v[29:0], rsp}, `RSP_RESP_SLVERR);
    wok(`RSP_OFS_PSC, 32'h00010002);
    rchk("psc lock", `RSP_OFS_PSC, 32'hffffffff, `RSP_PSC_RESET);
    // enter init, program dividers, leave init
    write_unlocked <= 1;
    wok(`RSP_OFS_STAT, 32'h80);
    rtc(1);
    rchk("init", `RSP_OFS_STAT, 32'hc0, 32'hc0);
    chk("wr ok", {31'd0, calendar_write_ok}, 1);
    chk("halt", {31'd0, counters_halt}, 1);
    pulse(4);
    rchk("calib init", `RSP_OFS_STAT, 32'h10000, 0);
    wok(`RSP_OFS_PSC, 32'hffff0002);
    rchk("psc", `RSP_OFS_PSC, 32'hffffffff, 32'h007f0002);
    wok(`RSP_OFS_PSC, 32'h00010002);
    wok(`RSP_OFS_STAT, 0);
    rchk("run", `RSP_OFS_STAT, 32'hc0, 0);
    // divide by 2 then by 3 over twelve rtc edges
    live_date <= 32'h00250101;
    a0 = n_async;
    s0 = n_sec;
    rtc(12);
    chk("async", n_async - a0, 6);
    chk("second", n_sec - s0, 2);
    rchk("sync", `RSP_OFS_STAT, 32'h30, 32'h30);
    live_date <= 32'h00260202;
    rchk("shadow", `RSP_OFS_DATE, 32'hffffffff, 32'h00250101);
    rchk("sh time", `RSP_OFS_TIME, 32'hffffffff, 32'h00123456);
    shadow_bypass <= 1;
    rchk("bypass", `RSP_OFS_DATE, 32'hffffffff, 32'h00260202);
    rchk("byp sync", `RSP_OFS_STAT, 32'h20, 0);
    shadow_bypass <= 0;
    rtc(2);
    rchk("resync", `RSP_OFS_STAT, 32'h20, 32'h20);
    wok(`RSP_OFS_STAT, 0);
    rchk("sw sync", `RSP_OFS_STAT, 32'h20, 0);
    shift_pending <= 1;
    alarm_enable <= 1;
    rtc(2);
    rchk("shift", `RSP_OFS_STAT, 32'h29, 32'h08);
    alarm_enable <= 0;
    shift_pending <= 0;
    // the writable flag follows the enable one clock later
    @(posedge clk);
    rchk("awf", `RSP_OFS_STAT, 32'h09, 32'h01);
    // system reset keeps sticky flags and divider factors
    wok(`RSP_OFS_STAT, 32'h80);
    rtc(1);
    pulse(0);
    reset <= 1;
    @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rchk("sysrst", `RSP_OFS_STAT, 32'h8e0, 32'h800);
    rchk("psc kept", `RSP_OFS_PSC, 32'hffffffff, 32'h00010002);
    live_date <= 0;
    bkp_reset <= 1;
    @(posedge clk);
    bkp_reset <= 0;
    @(posedge clk);
    rchk("bkp", `RSP_OFS_STAT, 32'hffffffff, 32'h7);
    rchk("bkp psc", `RSP_OFS_PSC, 32'hffffffff, `RSP_PSC_RESET);
    print_verdict;
  end
endmodule // tb_top
